// >>> hw/iam_consts.svh
// Purpose : register map, field positions and reset values of the entry matcher
// Assumes : included by its bare name
// Notes   : byte addresses on the avalon-mm slave
`ifndef IAM_CONSTS_SVH
`define IAM_CONSTS_SVH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define IAM_NUM_ENTRY   8
`define IAM_NUM_PORT    8

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define IAM_ENT_LAST    8'h7f
`define IAM_W_CTRL      2'h0
`define IAM_W_PORT      2'h1
`define IAM_W_VAL       2'h2
`define IAM_BIND_ADDR   8'h80
`define IAM_STAT_ADDR   8'h84

// ----------------------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------------------
`define IAM_C_VALID     0
`define IAM_C_DENY      1
`define IAM_C_LIST      2
`define IAM_C_DPM       4
`define IAM_C_TOSM      6
`define IAM_C_ICMPM     8
`define IAM_C_CODE      10
`define IAM_C_FLG       12

// ----------------------------------------------------------------------------
// value word fields and binding fields
// ----------------------------------------------------------------------------
`define IAM_V_DSCP      0
`define IAM_V_PREC      8
`define IAM_V_LSEL      12
`define IAM_V_ICMP      16
`define IAM_V_CODE      24
`define IAM_B_STRIDE    3

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define IAM_RST_WORD    32'h0000_0000
`define IAM_RST_CNT     16'h0000

`endif

// >>> hw/iam_pkg.sv
// Purpose : mode types of the entry matcher
// Assumes : codes match the 2-bit fields of the control word
// Notes   : 2'b11 is illegal in every field and fails the entry
package iam_pkg;

   typedef enum logic [1:0] {
      DP_ANY    = 2'b00,
      DP_SINGLE = 2'b01,
      DP_RANGE  = 2'b10
   } iam_dport_mode_t;

   typedef enum logic [1:0] {
      TOS_ANY  = 2'b00,
      TOS_DSCP = 2'b01,
      TOS_PREC = 2'b10
   } iam_tos_mode_t;

   typedef enum logic [1:0] {
      ICMP_ANY  = 2'b00,
      ICMP_LIST = 2'b01,
      ICMP_NUM  = 2'b10
   } iam_icmp_mode_t;

   typedef enum logic [1:0] {
      FLG_DC    = 2'b00,
      FLG_SET   = 2'b01,
      FLG_UNSET = 2'b10
   } iam_flag_mode_t;

endpackage

// >>> hw/iam_matcher.sv
// Purpose : classify parsed ingress frames against bound access-control entries
// Assumes : one parsed frame per cycle at most, fields valid with frm_valid
// Notes   : verdict one cycle after the frame; lowest matching entry wins
//
// Operation
// - single destination port mode passes only an equal 16-bit destination port
// - range destination port mode passes ports between lower and upper bound
// - service criterion any ignores the service field
// - dscp mode passes only an equal six-bit code point
// - precedence mode passes only an equal three-bit precedence
// - icmp type any puts no icmp constraint on the frame
// - list mode passes only the icmp type chosen from the fixed set
// - numeric identifier mode passes only an equal eight-bit icmp type
// - icmp code any ignores the icmp code
// - user code mode passes only an equal icmp code
// - urgent flag is set, unset or don't-care
// - acknowledgment flag is set, unset or don't-care
// - push flag is set, unset or don't-care
// - connection-reset flag is set, unset or don't-care
// - synchronize flag is set, unset or don't-care
// - finish flag is set, unset or don't-care
// - each port is bound to one list when its bound bit is set; only that list is evaluated, an unbound port evaluates none
// - deny hit discards the frame; permit hit forwards and learns
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`include "iam_consts.svh"

module iam_matcher (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // avalon-mm register slave
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // parsed frame from the ingress ports
   input  wire logic        frm_valid,
   input  wire logic [2:0]  frm_port,
   input  wire logic        frm_is_tcp,
   input  wire logic        frm_is_icmp,
   input  wire logic [15:0] frm_dport,
   input  wire logic [7:0]  frm_tos,
   input  wire logic [7:0]  frm_icmp_type,
   input  wire logic [7:0]  frm_icmp_code,
   input  wire logic [5:0]  frm_tcp_flags,
   // verdict
   output logic             res_valid,
   output logic             res_hit,
   output logic      [2:0]  res_entry,
   output logic             res_drop,
   output logic             res_learn
);

   // ----------------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------------
   logic [31:0] ent_ctrl_reg [`IAM_NUM_ENTRY];
   logic [31:0] ent_port_reg [`IAM_NUM_ENTRY];
   logic [31:0] ent_val_reg  [`IAM_NUM_ENTRY];
   logic [31:0] bind_reg;
   logic [15:0] permit_cnt_reg;
   logic [15:0] deny_cnt_reg;
   logic [31:0] rd_next;
   logic        wr_take;
   logic [7:0]  hit_vec;
   logic        any_hit;
   logic [2:0]  win_idx;
   logic [31:0] win_ctrl;
   logic [31:0] win_port;
   logic [31:0] win_val;
   logic        port_bound;
   logic [1:0]  port_list;

   // ----------------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------------
   // address lies inside the entry window on a mapped word
   function automatic logic is_entry(input logic [7:0] a);
      is_entry = (a <= `IAM_ENT_LAST) && (a[3:2] != 2'h3);
   endfunction

   // byte-lane merge so partial writes leave the other lanes alone
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      merge = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            merge[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction

   // fixed set of selectable icmp types
   function automatic logic [7:0] icmp_list(input logic [2:0] sel);
      unique case (sel)
         3'h0: icmp_list = 8'h00;  // echo reply
         3'h1: icmp_list = 8'h03;  // destination unreachable
         3'h2: icmp_list = 8'h04;  // source quench
         3'h3: icmp_list = 8'h05;  // redirect
         3'h4: icmp_list = 8'h08;  // echo request
         3'h5: icmp_list = 8'h0b;  // time exceeded
         3'h6: icmp_list = 8'h0c;  // parameter problem
         3'h7: icmp_list = 8'h0d;  // timestamp
      endcase
   endfunction

   // tri-state check of one tcp flag bit
   function automatic logic flag_ok(input logic [1:0] m, input logic bit_v);
      unique case (iam_pkg::iam_flag_mode_t'(m))
         iam_pkg::FLG_DC:    flag_ok = 1'b1;
         iam_pkg::FLG_SET:   flag_ok = bit_v;
         iam_pkg::FLG_UNSET: flag_ok = ~bit_v;
         default:            flag_ok = 1'b0;
      endcase
   endfunction

   // one entry against the current frame, all criteria anded
   function automatic logic entry_hit(input int unsigned e);
      logic [31:0] c;
      logic [31:0] p;
      logic [31:0] v;
      logic        ok;
      logic [1:0]  fm;
      c  = ent_ctrl_reg[e];
      p  = ent_port_reg[e];
      v  = ent_val_reg[e];
      ok = c[`IAM_C_VALID];
      fm = 2'h0;
      unique case (iam_pkg::iam_dport_mode_t'(c[`IAM_C_DPM +: 2]))
         iam_pkg::DP_ANY:    ok = ok;
         iam_pkg::DP_SINGLE: ok = ok & (frm_dport == p[15:0]);
         iam_pkg::DP_RANGE:  ok = ok & (frm_dport >= p[15:0]) & (frm_dport <= p[31:16]);
         default:            ok = 1'b0;
      endcase
      unique case (iam_pkg::iam_tos_mode_t'(c[`IAM_C_TOSM +: 2]))
         iam_pkg::TOS_ANY:  ok = ok;
         iam_pkg::TOS_DSCP: ok = ok & (frm_tos[7:2] == v[`IAM_V_DSCP +: 6]);
         iam_pkg::TOS_PREC: ok = ok & (frm_tos[7:5] == v[`IAM_V_PREC +: 3]);
         default:           ok = 1'b0;
      endcase
      // icmp criteria can only pass on a frame that carries an icmp header
      unique case (iam_pkg::iam_icmp_mode_t'(c[`IAM_C_ICMPM +: 2]))
         iam_pkg::ICMP_ANY:  ok = ok;
         iam_pkg::ICMP_LIST: ok = ok & frm_is_icmp & (frm_icmp_type == icmp_list(v[`IAM_V_LSEL +: 3]));
         iam_pkg::ICMP_NUM:  ok = ok & frm_is_icmp & (frm_icmp_type == v[`IAM_V_ICMP +: 8]);
         default:            ok = 1'b0;
      endcase
      if (c[`IAM_C_CODE]) begin
         ok = ok & frm_is_icmp & (frm_icmp_code == v[`IAM_V_CODE +: 8]);
      end  // code bit clear: code ignored
      // flags sit fin..urg at bits 0..5, as in the tcp header
      for (int k = 0; k < 6; k++) begin
         fm = c[`IAM_C_FLG + 2*k +: 2];
         if (fm != 2'h0) begin
            ok = ok & frm_is_tcp & flag_ok(fm, frm_tcp_flags[k]);
         end
      end
      entry_hit = ok;
   endfunction

   // ----------------------------------------------------------------------------
   // avalon-mm slave
   // ----------------------------------------------------------------------------
   // write commits only at the edge where waitrequest is seen low
   assign wr_take = avs_write & ~avs_waitrequest;

   // one wait cycle per access, then one cycle low to close it
   always_ff @(posedge mclk) begin
      if (reset) begin
         avs_waitrequest <= 1'b1;
      end else if ((avs_read | avs_write) & avs_waitrequest) begin
         avs_waitrequest <= 1'b0;
      end else begin
         avs_waitrequest <= 1'b1;
      end
   end

   // read mux; unmapped words read as zero
   always_comb begin
      rd_next = `IAM_RST_WORD;
      if (is_entry(avs_address)) begin
         unique case (avs_address[3:2])
            `IAM_W_CTRL: rd_next = ent_ctrl_reg[avs_address[6:4]];
            `IAM_W_PORT: rd_next = ent_port_reg[avs_address[6:4]];
            default:     rd_next = ent_val_reg[avs_address[6:4]];
         endcase
      end else if (avs_address == `IAM_BIND_ADDR) begin
         rd_next = bind_reg;
      end else if (avs_address == `IAM_STAT_ADDR) begin
         rd_next = {deny_cnt_reg, permit_cnt_reg};
      end
   end

   // read data caught in the wait cycle so it stands at the closing edge
   always_ff @(posedge mclk) begin
      if (reset) begin
         avs_readdata <= `IAM_RST_WORD;
      end else if (avs_read & avs_waitrequest) begin
         avs_readdata <= rd_next;
      end
   end

   // entry words; a write during traffic takes effect from the next frame
   always_ff @(posedge mclk) begin
      if (reset) begin
         for (int i = 0; i < `IAM_NUM_ENTRY; i++) begin
            ent_ctrl_reg[i] <= `IAM_RST_WORD;
            ent_port_reg[i] <= `IAM_RST_WORD;
            ent_val_reg[i]  <= `IAM_RST_WORD;
         end
      end else if (wr_take & is_entry(avs_address)) begin
         unique case (avs_address[3:2])
            `IAM_W_CTRL: ent_ctrl_reg[avs_address[6:4]] <=
               merge(ent_ctrl_reg[avs_address[6:4]], avs_writedata, avs_byteenable);
            `IAM_W_PORT: ent_port_reg[avs_address[6:4]] <=
               merge(ent_port_reg[avs_address[6:4]], avs_writedata, avs_byteenable);
            default:     ent_val_reg[avs_address[6:4]] <=
               merge(ent_val_reg[avs_address[6:4]], avs_writedata, avs_byteenable);
         endcase
      end
   end

   // port binding table: per port, bound bit and list number
   always_ff @(posedge mclk) begin
      if (reset) begin
         bind_reg <= `IAM_RST_WORD;
      end else if (wr_take & (avs_address == `IAM_BIND_ADDR)) begin
         bind_reg <= merge(bind_reg, avs_writedata, avs_byteenable) & 32'h00ff_ffff;
      end
   end

   // ----------------------------------------------------------------------------
   // classification
   // ----------------------------------------------------------------------------
   // binding of the arriving port
   assign port_bound = bind_reg[`IAM_B_STRIDE*frm_port];
   assign port_list  = bind_reg[`IAM_B_STRIDE*frm_port + 1 +: 2];

   // entries of other lists are never looked at
   always_comb begin
      for (int i = 0; i < `IAM_NUM_ENTRY; i++) begin
         hit_vec[i] = port_bound & (ent_ctrl_reg[i][`IAM_C_LIST +: 2] == port_list) &
                      entry_hit(i);
      end
   end

   // lowest index wins: the loop runs downward so the last write is the lowest
   always_comb begin
      any_hit = 1'b0;
      win_idx = 3'h0;
      for (int i = `IAM_NUM_ENTRY - 1; i >= 0; i--) begin
         if (hit_vec[i]) begin
            any_hit = 1'b1;
            win_idx = 3'(i);
         end
      end
   end

   assign win_ctrl = ent_ctrl_reg[win_idx];
   assign win_port = ent_port_reg[win_idx];
   assign win_val  = ent_val_reg[win_idx];

   // verdict, one cycle after the frame; no hit means forward
   always_ff @(posedge mclk) begin
      if (reset) begin
         res_valid <= 1'b0;
         res_hit   <= 1'b0;
         res_entry <= 3'h0;
         res_drop  <= 1'b0;
         res_learn <= 1'b0;
      end else begin
         res_valid <= frm_valid;
         res_hit   <= frm_valid & any_hit;
         res_entry <= win_idx;
         res_drop  <= frm_valid & any_hit & win_ctrl[`IAM_C_DENY];
         res_learn <= frm_valid & ~(any_hit & win_ctrl[`IAM_C_DENY]);
      end
   end

   // hit counters, wrapping; read back on the status word
   always_ff @(posedge mclk) begin
      if (reset) begin
         permit_cnt_reg <= `IAM_RST_CNT;
         deny_cnt_reg   <= `IAM_RST_CNT;
      end else if (frm_valid & any_hit) begin
         if (win_ctrl[`IAM_C_DENY]) begin
            deny_cnt_reg <= deny_cnt_reg + 16'h0001;
         end else begin
            permit_cnt_reg <= permit_cnt_reg + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------------
   a_single_dport: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && any_hit && win_ctrl[`IAM_C_DPM +: 2] == 2'h1 |-> frm_dport == win_port[15:0])
      else $error("single port hit with unequal port");

   a_range_dport: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && any_hit && win_ctrl[`IAM_C_DPM +: 2] == 2'h2
      |-> frm_dport >= win_port[15:0] && frm_dport <= win_port[31:16])
      else $error("range hit outside bounds");

   a_dscp_equal: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && any_hit && win_ctrl[`IAM_C_TOSM +: 2] == 2'h1
      |-> frm_tos[7:2] == win_val[`IAM_V_DSCP +: 6])
      else $error("dscp hit with other code point");

   a_prec_equal: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && any_hit && win_ctrl[`IAM_C_TOSM +: 2] == 2'h2
      |-> frm_tos[7:5] == win_val[`IAM_V_PREC +: 3])
      else $error("precedence hit with other value");

   a_code_equal: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && any_hit && win_ctrl[`IAM_C_CODE]
      |-> frm_is_icmp && frm_icmp_code == win_val[`IAM_V_CODE +: 8])
      else $error("code hit with other code");

   a_tcp_only: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && any_hit && !frm_is_tcp |-> win_ctrl[`IAM_C_FLG +: 12] == 12'h000)
      else $error("non-tcp frame hit a flag entry");

   a_flag_set: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && any_hit && win_ctrl[`IAM_C_FLG + 2 +: 2] == 2'h1 |-> frm_tcp_flags[1])
      else $error("set flag hit with flag clear");

   a_flag_unset: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && any_hit && win_ctrl[`IAM_C_FLG + 10 +: 2] == 2'h2 |-> !frm_tcp_flags[5])
      else $error("unset flag hit with flag set");

   a_bound_list: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && !port_bound |=> res_valid && !res_hit && !res_drop)
      else $error("unbound port produced a hit");

   a_deny_drop: assert property (@(posedge mclk) disable iff (reset)
      frm_valid && any_hit |=> res_drop == $past(win_ctrl[`IAM_C_DENY]) && res_learn != res_drop)
      else $error("deny hit not dropped");

   a_wait_cycle: assert property (@(posedge mclk) disable iff (reset)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("access not closed in one wait cycle");

endmodule

// >>> verif/iam_frame_src.sv
// Purpose : model of the ingress ports that hand parsed frames to the matcher
// Assumes : send is called away from a clock edge
// Notes   : idle fields invert every cycle so stale values never look like a frame
`timescale 1ns/10ps
module iam_frame_src (
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // parsed frame
   output logic             frm_valid,
   output logic      [2:0]  frm_port,
   output logic             frm_is_tcp,
   output logic             frm_is_icmp,
   output logic      [15:0] frm_dport,
   output logic      [7:0]  frm_tos,
   output logic      [7:0]  frm_icmp_type,
   output logic      [7:0]  frm_icmp_code,
   output logic      [5:0]  frm_tcp_flags
);
   logic        req  = 1'b0;
   logic        fv   = 1'b0;
   logic [50:0] hold = 51'h0;
   logic [50:0] fq   = 51'h0;

   // ------------------------------------------------------------------------
   // frame driver
   // ------------------------------------------------------------------------
   // one pulse per request, no backpressure exists so none is awaited
   always @(posedge mclk) begin
      fv <= req & ~reset;
      fq <= req ? hold : ~fq;
   end
   assign frm_valid = fv;
   assign {frm_port, frm_is_tcp, frm_is_icmp, frm_dport, frm_tos, frm_icmp_type, frm_icmp_code, frm_tcp_flags} = fq;

   // request taken by the driver at the next edge
   task send(input logic [50:0] f);
      #1;
      hold = f;
      req = 1'b1;
      @(posedge mclk);
      #1;
      req = 1'b0;
   endtask
endmodule

// >>> verif/tb_iam_matcher.sv
// Purpose : self-checking bench of the entry matcher
// Assumes : one wait cycle per bus access, verdict one cycle after a frame
// Notes   : expectations come from the control and value word layout
`timescale 1ns/10ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch at %0t got %h exp %h", $time, g, e); end end
module tb_iam_matcher;
   logic        mclk;
   logic        reset;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [3:0]  avs_byteenable;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        frm_valid, frm_is_tcp, frm_is_icmp;
   logic [2:0]  frm_port;
   logic [15:0] frm_dport;
   logic [7:0]  frm_tos, frm_icmp_type, frm_icmp_code;
   logic [5:0]  frm_tcp_flags;
   logic        res_valid, res_hit, res_drop, res_learn;
   logic [2:0]  res_entry;
   int          num_errors = 0;
   int          check_count = 0;
   logic [15:0] np = 16'h0;
   logic [15:0] nd = 16'h0;
   logic [7:0]  tbl [8] = '{8'h00, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0b, 8'h0c, 8'h0d};

   // 10 MHz clock
   always #50 mclk = ~mclk;

   iam_frame_src u_src (.mclk(mclk), .reset(reset), .frm_valid(frm_valid), .frm_port(frm_port),
      .frm_is_tcp(frm_is_tcp), .frm_is_icmp(frm_is_icmp), .frm_dport(frm_dport), .frm_tos(frm_tos),
      .frm_icmp_type(frm_icmp_type), .frm_icmp_code(frm_icmp_code), .frm_tcp_flags(frm_tcp_flags));
   iam_matcher u_dut (.mclk(mclk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .frm_valid(frm_valid),
      .frm_port(frm_port), .frm_is_tcp(frm_is_tcp), .frm_is_icmp(frm_is_icmp), .frm_dport(frm_dport),
      .frm_tos(frm_tos), .frm_icmp_type(frm_icmp_type), .frm_icmp_code(frm_icmp_code),
      .frm_tcp_flags(frm_tcp_flags), .res_valid(res_valid), .res_hit(res_hit), .res_entry(res_entry),
      .res_drop(res_drop), .res_learn(res_learn));

   // ------------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------------
   task end_sim();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // request held until waitrequest is seen low; a hung slave ends the run
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be,
            output logic [31:0] q);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_read <= ~wr;
      avs_write <= wr;
      for (n = 0; n < 50; n++) begin
         @(posedge mclk);
         if (avs_waitrequest === 1'b0) break;
      end
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n == 50) begin
         num_errors++;
         $display("mismatch at %0t bus timeout", $time);
         end_sim();
      end
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hf, q);
   endtask

   task rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hf, q);
      `CHK(q, e)
   endtask

   // control word: flags, code, icmp, tos, dport, list, deny, valid
   function automatic logic [31:0] mk(input logic dn, input logic [1:0] ls, dp, ts, ic,
                                      input logic cd, input logic [11:0] fl);
      return {8'h00, fl, 1'b0, cd, ic, ts, dp, ls, dn, 1'b1};
   endfunction

   function automatic logic [50:0] fr(input logic [2:0] p = 3'h0, input logic tcp = 1'b0,
      input logic icmp = 1'b0, input logic [15:0] dp = 16'h0000, input logic [7:0] tos = 8'h00,
      input logic [7:0] it = 8'h00, input logic [7:0] ic = 8'h00, input logic [5:0] fl = 6'h00);
      return {p, tcp, icmp, dp, tos, it, ic, fl};
   endfunction

   task ent(input logic [2:0] e, input logic [31:0] c, p, v);
      wr({1'b0, e, 4'h0}, c);
      wr({1'b0, e, 4'h4}, p);
      wr({1'b0, e, 4'h8}, v);
   endtask

   // verdict stands one cycle after the frame edge; no hit forwards and learns
   task frame(input logic [50:0] f, input logic hit, input logic [2:0] e, input logic drop);
      u_src.send(f);
      @(posedge mclk);
      #1;
      `CHK(res_valid, 1'b1)
      `CHK(res_hit, hit)
      `CHK(res_entry, e)
      `CHK(res_drop, drop)
      `CHK(res_learn, ~drop)
      if (hit && drop) nd++;
      if (hit && !drop) np++;
   endtask

   // ------------------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------------------
   task t_reg();
      logic [31:0] q;
      rdc(8'h00, 32'h0);
      rdc(8'h80, 32'h0);
      rdc(8'h84, 32'h0);
      wr(8'h0c, 32'hffff_ffff);
      rdc(8'h0c, 32'h0);
      bus(1'b1, 8'h70, 32'hffff_ffff, 4'h2, q);
      rdc(8'h70, 32'h0000_ff00);
      wr(8'h70, 32'h0);
      $display("test reg done");
   endtask

   task t_dport();
      wr(8'h80, 32'h0000_0001);
      ent(3'h0, mk(1'b1, 2'h0, iam_pkg::DP_SINGLE, iam_pkg::TOS_ANY, iam_pkg::ICMP_ANY, 1'b0, 12'h0), 32'h50, 32'h0);
      frame(fr(.dp(16'h0050)), 1'b1, 3'h0, 1'b1);
      frame(fr(.dp(16'h0051)), 1'b0, 3'h0, 1'b0);
      ent(3'h0, mk(1'b1, 2'h0, iam_pkg::DP_SINGLE, iam_pkg::TOS_ANY, iam_pkg::ICMP_ANY, 1'b0, 12'h0), 32'hffff, 32'h0);
      frame(fr(.dp(16'hffff)), 1'b1, 3'h0, 1'b1);
      frame(fr(.dp(16'h0000)), 1'b0, 3'h0, 1'b0);
      ent(3'h0, mk(1'b1, 2'h0, iam_pkg::DP_RANGE, iam_pkg::TOS_ANY, iam_pkg::ICMP_ANY, 1'b0, 12'h0),
          32'hc8_0064, 32'h0);
      frame(fr(.dp(16'h0064)), 1'b1, 3'h0, 1'b1);
      frame(fr(.dp(16'h00c8)), 1'b1, 3'h0, 1'b1);
      frame(fr(.dp(16'h0063)), 1'b0, 3'h0, 1'b0);
      frame(fr(.dp(16'h00c9)), 1'b0, 3'h0, 1'b0);
      $display("test dport done");
   endtask

   task t_tos();
      ent(3'h0, mk(1'b0, 2'h0, iam_pkg::DP_SINGLE, iam_pkg::TOS_DSCP, iam_pkg::ICMP_ANY, 1'b0, 12'h0), 32'h50, 32'h2e);
      frame(fr(.dp(16'h0050), .tos(8'hbb)), 1'b1, 3'h0, 1'b0);
      frame(fr(.dp(16'h0050), .tos(8'hbc)), 1'b0, 3'h0, 1'b0);
      frame(fr(.dp(16'h0051), .tos(8'hb8)), 1'b0, 3'h0, 1'b0);
      ent(3'h0, mk(1'b0, 2'h0, iam_pkg::DP_ANY, iam_pkg::TOS_PREC, iam_pkg::ICMP_ANY, 1'b0, 12'h0), 32'h0, 32'h500);
      frame(fr(.tos(8'hbf)), 1'b1, 3'h0, 1'b0);
      frame(fr(.tos(8'hc0)), 1'b0, 3'h0, 1'b0);
      ent(3'h0, mk(1'b0, 2'h0, iam_pkg::DP_ANY, iam_pkg::TOS_ANY, iam_pkg::ICMP_ANY, 1'b0, 12'h0), 32'h0, 32'h0);
      frame(fr(.tos(8'h5a), .dp(16'h1234)), 1'b1, 3'h0, 1'b0);
      $display("test tos done");
   endtask

   task t_icmp();
      for (int s = 0; s < 8; s++) begin
         ent(3'h0, mk(1'b0, 2'h0, iam_pkg::DP_ANY, iam_pkg::TOS_ANY, iam_pkg::ICMP_LIST, 1'b0, 12'h0), 32'h0, s << 12);
         frame(fr(.icmp(1'b1), .it(tbl[s])), 1'b1, 3'h0, 1'b0);
         frame(fr(.icmp(1'b1), .it(tbl[s] + 8'h01)), 1'b0, 3'h0, 1'b0);
      end
      ent(3'h0, mk(1'b0, 2'h0, iam_pkg::DP_ANY, iam_pkg::TOS_ANY, iam_pkg::ICMP_NUM, 1'b0, 12'h0), 32'h0, 32'hc8_0000);
      frame(fr(.icmp(1'b1), .it(8'hc8)), 1'b1, 3'h0, 1'b0);
      frame(fr(.icmp(1'b1), .it(8'hc7)), 1'b0, 3'h0, 1'b0);
      ent(3'h0, mk(1'b0, 2'h0, iam_pkg::DP_ANY, iam_pkg::TOS_ANY, iam_pkg::ICMP_ANY, 1'b1, 12'h0),
          32'h0, 32'h0700_0000);
      frame(fr(.icmp(1'b1), .ic(8'h07)), 1'b1, 3'h0, 1'b0);
      frame(fr(.icmp(1'b1), .ic(8'h08)), 1'b0, 3'h0, 1'b0);
      wr(8'h00, mk(1'b0, 2'h0, iam_pkg::DP_ANY, iam_pkg::TOS_ANY, iam_pkg::ICMP_ANY, 1'b0, 12'h0));
      frame(fr(.icmp(1'b1), .it(8'hff), .ic(8'hff)), 1'b1, 3'h0, 1'b0);
      frame(fr(.tcp(1'b1), .it(8'h5a), .ic(8'ha5)), 1'b1, 3'h0, 1'b0);
      $display("test icmp done");
   endtask

   // each flag set, then unset, against both bit values and a non-tcp frame
   task t_flags();
      logic [5:0] b;
      for (int i = 0; i < 6; i++) begin
         b = 6'h01 << i;
         wr(8'h00, mk(1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 12'h001 << (2 * i)));
         frame(fr(.tcp(1'b1), .fl(b)), 1'b1, 3'h0, 1'b0);
         frame(fr(.tcp(1'b1), .fl(~b)), 1'b0, 3'h0, 1'b0);
         frame(fr(.fl(b)), 1'b0, 3'h0, 1'b0);
         wr(8'h00, mk(1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 12'h002 << (2 * i)));
         frame(fr(.tcp(1'b1), .fl(~b)), 1'b1, 3'h0, 1'b0);
         frame(fr(.tcp(1'b1), .fl(b)), 1'b0, 3'h0, 1'b0);
         frame(fr(.fl(~b)), 1'b0, 3'h0, 1'b0);
      end
      $display("test flags done");
   endtask

   task t_bind();
      ent(3'h0, mk(1'b1, 2'h1, iam_pkg::DP_SINGLE, iam_pkg::TOS_ANY, iam_pkg::ICMP_ANY, 1'b0, 12'h0), 32'h50, 32'h0);
      wr(8'h10, mk(1'b0, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 12'h0));
      wr(8'h20, mk(1'b1, 2'h0, 2'h0, 2'h0, 2'h0, 1'b0, 12'h0));
      wr(8'h80, 32'h0000_0019);
      frame(fr(.p(3'h0), .dp(16'h0050)), 1'b1, 3'h1, 1'b0);
      frame(fr(.p(3'h1), .dp(16'h0050)), 1'b1, 3'h0, 1'b1);
      frame(fr(.p(3'h1), .dp(16'h0051)), 1'b0, 3'h0, 1'b0);
      frame(fr(.p(3'h2), .dp(16'h0050)), 1'b0, 3'h0, 1'b0);
      wr(8'h10, 32'h0);
      frame(fr(.p(3'h0), .dp(16'h0050)), 1'b1, 3'h2, 1'b1);
      wr(8'h84, 32'hffff_ffff);
      rdc(8'h84, {nd, np});
      $display("test bind done");
   endtask

   // ------------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------------
   initial begin
      // start values set here so the bus inputs are driven, not tied
      mclk = 1'b0;
      reset <= 1'b1;
      avs_address <= 8'h00;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_writedata <= 32'h0;
      avs_byteenable <= 4'h0;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      t_reg();
      t_dport();
      t_tos();
      t_icmp();
      t_flags();
      t_bind();
      end_sim();
   end
endmodule
